// ==== inc/mgb_map.vh ====
`ifndef MGB_MAP_VH
`define MGB_MAP_VH
// ************************************************************
// Register offsets
// ************************************************************
`define MGB_OFS_BEEP 7'h0a
`define MGB_OFS_PHONE 7'h0c
`define MGB_OFS_MIC 7'h0e
`define MGB_OFS_LINE 7'h10
`define MGB_OFS_DISC 7'h12
`define MGB_OFS_AUX 7'h16
`define MGB_OFS_FRONT 7'h18
`define MGB_OFS_RECSEL 7'h1a
// ************************************************************
// Reset values
// ************************************************************
`define MGB_RST_BEEP 16'h8000
`define MGB_RST_PHONE 16'h8008
`define MGB_RST_STEREO 16'h8888
`define MGB_RST_RECSEL 16'h0000
// ************************************************************
// Writable bit masks (reserved bits read as zero)
// ************************************************************
`define MGB_MASK_BEEP 16'hdffe
`define MGB_MASK_PHONE 16'h801f
`define MGB_MASK_STEREO 16'h9f9f
`define MGB_MASK_MIC 16'h9fdf
`define MGB_MASK_RECSEL 16'h0707
// ************************************************************
// Field positions
// ************************************************************
`define MGB_LEFT_MUTE 15
`define MGB_LEFT_GAIN_HI 12
`define MGB_LEFT_GAIN_LO 8
`define MGB_RIGHT_MUTE 7
`define MGB_RIGHT_GAIN_HI 4
`define MGB_RIGHT_GAIN_LO 0
`define MGB_MIC_BOOST 6
`define MGB_BEEP_MUTE 15
`define MGB_BEEP_SRC 14
`define MGB_BEEP_FREQ_HI 12
`define MGB_BEEP_FREQ_LO 5
`define MGB_BEEP_VOL_HI 4
`define MGB_BEEP_VOL_LO 1
`define MGB_LSRC_HI 10
`define MGB_LSRC_LO 8
`define MGB_RSRC_HI 2
`define MGB_RSRC_LO 0
// ************************************************************
// Timing: 48 kHz reference tick from the 25 MHz clock
// ************************************************************
`define MGB_CLK_HZ 25000000
`define MGB_TONE_REF_HZ 48000
`define MGB_TONE_REF_DIV (`MGB_CLK_HZ / `MGB_TONE_REF_HZ)
// Last count of the reference divider, one below the divide ratio of 520.
`define MGB_TONE_REF_LAST 10'd519
`define MGB_BOOST_SEL_20DB 2'b00
`define MGB_BOOST_SEL_10DB 2'b01
`endif

// ==== verilog/mgb_regs.v ====
`timescale 1ns/1ps
`include "mgb_map.vh"

module mgb_regs (
  input wire clk_sys,
  input wire nrst,
  input wire reg_wr,
  input wire reg_rd,
  input wire [6:0] reg_addr,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata,
  output reg reg_rvalid,
  input wire beep_analog_input,
  input wire [1:0] boost_level_select,
  output reg beep_to_outputs,
  output reg beep_active,
  output reg [3:0] beep_volume,
  output reg phone_mute,
  output reg [4:0] phone_gain,
  output reg [9:0] mic_left_ctl,
  output reg [9:0] mic_right_ctl,
  output reg [4:0] mic_boost_db,
  output reg [11:0] line_ctl,
  output reg [11:0] disc_ctl,
  output reg [11:0] aux_ctl,
  output reg [11:0] front_ctl,
  output reg [2:0] left_record_source,
  output reg [2:0] right_record_source
);

  // ************************************************************
  // Register storage
  // ************************************************************
  reg [15:0] beep_r;
  reg [15:0] phone_r;
  reg [15:0] mic_r;
  reg [15:0] line_r;
  reg [15:0] disc_r;
  reg [15:0] aux_r;
  reg [15:0] front_r;
  reg [15:0] recsel_r;
  reg [15:0] rdata_nxt;

  // Reserved bits are masked on write so they always read back as zero.
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      beep_r <= `MGB_RST_BEEP;
      phone_r <= `MGB_RST_PHONE;
      mic_r <= `MGB_RST_STEREO;
      line_r <= `MGB_RST_STEREO;
      disc_r <= `MGB_RST_STEREO;
      aux_r <= `MGB_RST_STEREO;
      front_r <= `MGB_RST_STEREO;
      recsel_r <= `MGB_RST_RECSEL;
    end else if (reg_wr) begin
      case (reg_addr)
        `MGB_OFS_BEEP: beep_r <= reg_wdata & `MGB_MASK_BEEP;
        `MGB_OFS_PHONE: phone_r <= reg_wdata & `MGB_MASK_PHONE;
        `MGB_OFS_MIC: mic_r <= reg_wdata & `MGB_MASK_MIC;
        `MGB_OFS_LINE: line_r <= reg_wdata & `MGB_MASK_STEREO;
        `MGB_OFS_DISC: disc_r <= reg_wdata & `MGB_MASK_STEREO;
        `MGB_OFS_AUX: aux_r <= reg_wdata & `MGB_MASK_STEREO;
        `MGB_OFS_FRONT: front_r <= reg_wdata & `MGB_MASK_STEREO;
        `MGB_OFS_RECSEL: recsel_r <= reg_wdata & `MGB_MASK_RECSEL;
        default: begin
        end
      endcase
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  always @* begin
    case (reg_addr)
      `MGB_OFS_BEEP: rdata_nxt = beep_r;
      `MGB_OFS_PHONE: rdata_nxt = phone_r;
      `MGB_OFS_MIC: rdata_nxt = mic_r;
      `MGB_OFS_LINE: rdata_nxt = line_r;
      `MGB_OFS_DISC: rdata_nxt = disc_r;
      `MGB_OFS_AUX: rdata_nxt = aux_r;
      `MGB_OFS_FRONT: rdata_nxt = front_r;
      `MGB_OFS_RECSEL: rdata_nxt = recsel_r;
      default: rdata_nxt = 16'h0000;
    endcase
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_nxt;
      end
    end
  end

  // ************************************************************
  // Tone generator
  // ************************************************************
  // A 48 kHz tick comes from a divider; the half period is 2*F ticks, so
  // one full period is 4*F ticks of the reference.
  reg [9:0] ref_cnt_r;
  reg ref_tick_r;
  reg [8:0] half_cnt_r;
  reg tone_r;
  wire [7:0] freq = beep_r[`MGB_BEEP_FREQ_HI:`MGB_BEEP_FREQ_LO];
  wire [8:0] half_len = {freq, 1'b0};

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ref_cnt_r <= 10'h000;
      ref_tick_r <= 1'b0;
    end else if (ref_cnt_r == `MGB_TONE_REF_LAST) begin
      ref_cnt_r <= 10'h000;
      ref_tick_r <= 1'b1;
    end else begin
      ref_cnt_r <= ref_cnt_r + 10'h001;
      ref_tick_r <= 1'b0;
    end
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      half_cnt_r <= 9'h000;
      tone_r <= 1'b0;
    end else if (freq == 8'h00) begin
      half_cnt_r <= 9'h000;
      tone_r <= 1'b0;
    end else if (ref_tick_r) begin
      if (half_cnt_r >= half_len - 9'h001) begin
        half_cnt_r <= 9'h000;
        tone_r <= ~tone_r;
      end else begin
        half_cnt_r <= half_cnt_r + 9'h001;
      end
    end
  end

  // ************************************************************
  // Beep routing and mixer controls
  // ************************************************************
  // Reset bypass is asynchronous in the analog part; here only the flag
  // beep_to_outputs is driven high while nrst is low, not the raw pin level.
  wire beep_src = beep_r[`MGB_BEEP_SRC] ? beep_analog_input : tone_r;

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      beep_to_outputs <= 1'b1;
      beep_active <= 1'b0;
      beep_volume <= 4'h0;
      phone_mute <= 1'b1;
      phone_gain <= 5'h08;
      mic_left_ctl <= 10'h000;
      mic_right_ctl <= 10'h000;
      mic_boost_db <= 5'h00;
      line_ctl <= 12'h000;
      disc_ctl <= 12'h000;
      aux_ctl <= 12'h000;
      front_ctl <= 12'h000;
      left_record_source <= 3'h0;
      right_record_source <= 3'h0;
    end else begin
      beep_to_outputs <= 1'b0;
      beep_active <= ~beep_r[`MGB_BEEP_MUTE] & beep_src;
      beep_volume <= beep_r[`MGB_BEEP_VOL_HI:`MGB_BEEP_VOL_LO];
      phone_mute <= phone_r[`MGB_LEFT_MUTE];
      phone_gain <= phone_r[`MGB_RIGHT_GAIN_HI:`MGB_RIGHT_GAIN_LO];
      mic_left_ctl <= {5'h00, mic_r[`MGB_LEFT_MUTE], mic_r[11:8]} |
        {mic_r[`MGB_LEFT_GAIN_HI], 9'h000};
      mic_right_ctl <= {5'h00, mic_r[`MGB_RIGHT_MUTE], mic_r[3:0]} |
        {mic_r[`MGB_RIGHT_GAIN_HI], 9'h000};
      if (!mic_r[`MGB_MIC_BOOST]) begin
        mic_boost_db <= 5'd0;
      end else if (boost_level_select == `MGB_BOOST_SEL_20DB) begin
        mic_boost_db <= 5'd20;
      end else if (boost_level_select == `MGB_BOOST_SEL_10DB) begin
        mic_boost_db <= 5'd10;
      end else begin
        mic_boost_db <= 5'd0;
      end
      line_ctl <= {line_r[15], line_r[12:8], line_r[7], line_r[4:0]};
      disc_ctl <= {disc_r[15], disc_r[12:8], disc_r[7], disc_r[4:0]};
      aux_ctl <= {aux_r[15], aux_r[12:8], aux_r[7], aux_r[4:0]};
      front_ctl <= {front_r[15], front_r[12:8], front_r[7], front_r[4:0]};
      left_record_source <= recsel_r[`MGB_LSRC_HI:`MGB_LSRC_LO];
      right_record_source <= recsel_r[`MGB_RSRC_HI:`MGB_RSRC_LO];
    end
  end

endmodule // mgb_regs

// ==== sim/mgb_ctl.sv ====
`timescale 1ns/1ps
module mgb_ctl (
  input wire clk_sys,
  output reg reg_wr,
  output reg reg_rd,
  output reg [6:0] reg_addr,
  output reg [15:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 16'h0000;
  end
  // Released address and data lines are inverted so a stale value never looks valid.
  task xfer(input w, input [6:0] a, input [15:0] d);
    begin
      @(negedge clk_sys);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = w;
      reg_rd = !w;
      @(negedge clk_sys);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
    end
  endtask
endmodule // mgb_ctl

// ==== sim/mgb_regs_chk.sv ====
`timescale 1ns/1ps
module mgb_regs_chk (
  input wire clk_sys,
  input wire nrst,
  input wire reg_wr,
  input wire reg_rd,
  input wire [6:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_rvalid,
  input wire beep_to_outputs,
  input wire beep_active,
  input wire [3:0] beep_volume,
  input wire phone_mute,
  input wire [4:0] phone_gain,
  input wire [11:0] line_ctl,
  input wire [2:0] left_record_source
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  wire w_beep = reg_wr && reg_addr == 7'h0a;
  wire w_line = reg_wr && reg_addr == 7'h10;
  wire w_rec = reg_wr && reg_addr == 7'h1a;
  wire w_ph = reg_wr && reg_addr == 7'h0c;
  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read got no valid pulse");
  a_valid_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("valid pulse without a read");
  a_line_write: assert property (w_line |-> ##2 line_ctl ==
    {$past(reg_wdata[15], 2), $past(reg_wdata[12:8], 2), $past(reg_wdata[7], 2),
    $past(reg_wdata[4:0], 2)}) else $error("line control not updated");
  a_rec_write: assert property (
    w_rec |-> ##2 left_record_source == $past(reg_wdata[10:8], 2))
    else $error("record source not updated");
  a_beep_vol: assert property (
    w_beep |-> ##2 beep_volume == $past(reg_wdata[4:1], 2))
    else $error("beep volume not updated");
  a_beep_mute: assert property (w_beep && reg_wdata[15] |-> ##2 !beep_active)
    else $error("muted beep still active");
  a_phone_write: assert property (w_ph |-> ##2 phone_gain ==
    $past(reg_wdata[4:0], 2) && phone_mute == $past(reg_wdata[15], 2))
    else $error("phone control not updated");
  a_bypass_on: assert property (disable iff (1'b0) !nrst |-> beep_to_outputs)
    else $error("no beep bypass in reset");
  c_tone: cover property ($rose(beep_active));
  c_line: cover property (w_line);
  c_read: cover property (reg_rd ##1 reg_rvalid);
endmodule // mgb_regs_chk
bind mgb_regs mgb_regs_chk u_chk (.clk_sys, .nrst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
  .reg_rvalid, .beep_to_outputs, .beep_active, .beep_volume, .phone_mute, .phone_gain,
  .line_ctl, .left_record_source);

// ==== sim/tb.sv ====
`timescale 1ns/1ps
module tb;
  reg clk_sys;
  reg nrst = 1'b1;
  reg beep_analog_input = 1'b0;
  reg [1:0] boost_level_select = 2'b00;
  wire reg_wr, reg_rd, reg_rvalid, beep_to_outputs, beep_active, phone_mute;
  wire [6:0] reg_addr;
  wire [15:0] reg_wdata, reg_rdata;
  wire [3:0] beep_volume;
  wire [4:0] phone_gain, mic_boost_db;
  wire [11:0] line_ctl, disc_ctl, aux_ctl, front_ctl;
  wire [2:0] left_record_source, right_record_source;
  wire [9:0] mic_left_ctl, mic_right_ctl;
  integer fail_count = 0;
  integer cmp_count = 0;
  integer cyc = 0;
  integer i, n;
  localparam [55:0] ADS = {7'h0a, 7'h0c, 7'h0e, 7'h10, 7'h12, 7'h16, 7'h18, 7'h1a};
  localparam [127:0] RSV = {16'h8000, 16'h8008, {5{16'h8888}}, 16'h0000};
  localparam [127:0] MSK = {16'hdffe, 16'h801f, 16'h9fdf, {4{16'h9f9f}}, 16'h0707};
  mgb_ctl u_ctl (.clk_sys, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  mgb_regs u_dut (.clk_sys, .nrst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_rvalid, .beep_analog_input, .boost_level_select, .beep_to_outputs, .beep_active,
    .beep_volume, .phone_mute, .phone_gain, .mic_left_ctl, .mic_right_ctl, .mic_boost_db,
    .line_ctl, .disc_ctl, .aux_ctl, .front_ctl, .left_record_source, .right_record_source);
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task chk(input [63:0] nm, input [15:0] got, input [15:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  // Outputs trail a write by two edges, so three are allowed before looking.
  task wr(input [6:0] a, input [15:0] d);
    begin
      u_ctl.xfer(1'b1, a, d);
      repeat (3) @(posedge clk_sys);
      #1;
    end
  endtask
  task rdc(input [6:0] a, input [15:0] e);
    begin
      u_ctl.xfer(1'b0, a, 16'h0000);
      @(posedge clk_sys);
      #1;
      chk("rdata", reg_rdata, e);
    end
  endtask
  task run(input v);
    begin
      n = 0;
      while (beep_active !== v && n < 3000) begin
        @(posedge clk_sys);
        #1;
        n = n + 1;
      end
    end
  endtask
  task close_out;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      close_out;
    end
  end
  initial begin
    #1 nrst = 1'b0;
    repeat (20) @(negedge clk_sys);
    chk("bypass", beep_to_outputs, 16'h0001);
    nrst = 1'b1;
    for (i = 0; i < 8; i = i + 1)
      rdc(ADS[i*7+:7], RSV[i*16+:16]);
    chk("bypass", beep_to_outputs, 16'h0000);
    for (i = 0; i < 8; i = i + 1) begin
      u_ctl.xfer(1'b1, ADS[i*7+:7], 16'hffff);
      rdc(ADS[i*7+:7], MSK[i*16+:16]);
    end
    u_ctl.xfer(1'b1, 7'h14, 16'hffff);
    rdc(7'h14, 16'h0000);
    $display("test registers done");
    wr(7'h10, 16'h1f05);
    wr(7'h12, 16'h0080);
    wr(7'h16, 16'h8000);
    wr(7'h18, 16'h0a1f);
    chk("line", line_ctl, 16'h07c5);
    chk("disc", disc_ctl, 16'h0020);
    chk("aux", aux_ctl, 16'h0800);
    chk("front", front_ctl, 16'h029f);
    wr(7'h0c, 16'h001f);
    chk("phone", {phone_mute, phone_gain}, 16'h001f);
    for (i = 0; i < 8; i = i + 1) begin
      wr(7'h1a, {5'h00, i[2:0], 5'h00, ~i[2:0]});
      chk("recsrc", {left_record_source, right_record_source}, {i[2:0], ~i[2:0]});
    end
    for (i = 0; i < 3; i = i + 1) begin
      @(negedge clk_sys);
      boost_level_select = i[1:0];
      wr(7'h0e, 16'h0040);
      chk("boost", mic_boost_db, i == 0 ? 16'h0014 : i == 1 ? 16'h000a : 16'h0000);
    end
    wr(7'h0e, 16'h1785);
    chk("mic_l", mic_left_ctl, 16'h0207);
    chk("mic_r", mic_right_ctl, 16'h0015);
    wr(7'h0e, 16'h0000);
    chk("boost", mic_boost_db, 16'h0000);
    $display("test mixer done");
    wr(7'h0a, 16'h0020);
    run(1'b1);
    run(1'b0);
    run(1'b1);
    chk("tone_lo", n[15:0], 16'h0410);
    run(1'b0);
    chk("tone_hi", n[15:0], 16'h0410);
    wr(7'h0a, 16'h401e);
    chk("volume", beep_volume, 16'h000f);
    @(negedge clk_sys);
    beep_analog_input = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk("analog", beep_active, 16'h0001);
    wr(7'h0a, 16'hc01e);
    chk("muted", beep_active, 16'h0000);
    $display("test beep done");
    close_out;
  end
endmodule // tb
